/* tb/axis_far_side.sv */
// Far side model: motor driver alarm output and a peer on the start line.
`timescale 1ns/1ns
`default_nettype none
module axis_far_side (
  input wire logic ref_clk,
  input wire logic alarmOn,
  input wire logic alarmHigh,
  input wire logic fire,
  input wire logic hold,
  output logic alarmPin,
  output logic pullLow
);
  logic [2:0] left = 3'h0;

  // The alarm width is set by how long the bench keeps alarmOn high.
  assign alarmPin = alarmOn ? alarmHigh : ~alarmHigh;

  // A peer trigger pulls the shared line low for four cycles.
  always_ff @(posedge ref_clk) begin
    if (fire) begin
      left <= 3'h4;
    end else if (left != 3'h0) begin
      left <= left - 3'h1;
    end
  end

  assign pullLow = hold | (left != 3'h0);
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the axis alarm stop and common start block.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import axis_alarm_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awAddr = 8'h00;
  logic [7:0] arAddr = 8'h00;
  logic [31:0] wData = 32'h0;
  logic awValid = 1'b0;
  logic wValid = 1'b0;
  logic arValid = 1'b0;
  logic bReady = 1'b1;
  logic rReady = 1'b1;
  logic feedDone = 1'b0;
  logic alarmOn = 1'b0;
  logic alarmHigh = 1'b0;
  logic fire = 1'b0;
  logic hold = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  logic lineOut, lineOe, feedRun, decelStop, irqReq;
  wire alarmPin, pullLow, lineIn;
  logic [33:0] expR[$];
  logic [31:0] expM[$];
  logic [1:0] expB[$];
  logic [31:0] seed = 32'h60;
  logic [7:0] cmd;
  logic dec;
  int fail_count = 0;
  int n_tests = 0;
  int oeCnt = 0;
  int o;

  always #50 ref_clk = ~ref_clk;

  // Open-drain wire with a pull-up: low when any party pulls it.
  assign lineIn = (lineOe ? lineOut : 1'b1) & ~pullLow;

  axis_alarm_stop_and_sync_start DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .alarmIn(alarmPin), .startLineIn(lineIn),
    .startLineOut(lineOut), .startLineOe(lineOe), .feedDone(feedDone),
    .feedRun(feedRun), .decelStop(decelStop), .irqReq(irqReq));

  axis_far_side FAR (.ref_clk(ref_clk), .alarmOn(alarmOn),
    .alarmHigh(alarmHigh), .fire(fire), .hold(hold),
    .alarmPin(alarmPin), .pullLow(pullLow));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [39:0] e, input logic [39:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    logic aw, w;
    expB.push_back(r);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    do begin
      @(posedge ref_clk);
      aw |= awReady;
      w |= wReady;
      if (aw) awValid <= 1'b0;
      if (w) wValid <= 1'b0;
    end while (!(aw && w));
    do @(posedge ref_clk); while (!bValid);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] r,
                    input logic [31:0] v, input logic [31:0] m);
    expR.push_back({r, v & m});
    expM.push_back(m);
    arAddr <= a;
    arValid <= 1'b1;
    do @(posedge ref_clk); while (!arReady);
    arValid <= 1'b0;
    do @(posedge ref_clk); while (!rValid);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Monitors
  // ------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (lineOe === 1'b1) oeCnt++;
    if (bValid && bReady) chk(expB.pop_front(), bResp);
    if (rValid && rReady) begin
      chk(expR.pop_front(), {rResp, rData & expM.pop_front()});
    end
  end

  // The whole sequence needs under 1000 cycles; twenty times that is a hang.
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    test_done();
  end

  // ------------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(2);
    rd(OFS_ENV, RESP_OKAY, 32'h0, '1);
    rd(OFS_SUBSTAT, RESP_OKAY, 32'h0, 32'h800);
    rd(8'h20 + 8'(rnd() % 56) * 8'h4, RESP_SLVERR, 32'h0, '1);
    wr(OFS_SUBSTAT, rnd(), RESP_SLVERR);
    note("registers");
    for (int p = 0; p < 2; p++) begin
      wr(OFS_ENV, 32'(p) << ENV_ALARM_POL_BIT);
      alarmHigh <= p[0];
      cyc(8);
      rd(OFS_SUBSTAT, RESP_OKAY, 32'h0, 32'h800);
      wr(OFS_COMMAND, CMD_START_CONST);
      cyc(2);
      chk(feedRun, 1'b1);
      rd(OFS_EXTSTAT, RESP_OKAY, OPER_RUN, 32'hF);
      alarmOn <= 1'b1;
      cyc(8);
      chk(feedRun, 1'b0);
      rd(OFS_SUBSTAT, RESP_OKAY, 32'h800, 32'h800);
      rd(OFS_STOPCAUSE, RESP_OKAY, 32'h80, 32'h80);
      wr(OFS_COMMAND, CMD_START_CONST);
      cyc(4);
      chk(feedRun, 1'b0);
      rd(OFS_STOPCAUSE, RESP_OKAY, 32'h80, 32'h80);
      alarmOn <= 1'b0;
      cyc(8);
    end
    note("alarm polarity and halt");
    for (int i = 0; i < 3; i++) begin
      cmd = (i == 1) ? CMD_START_FAST : CMD_START_CONST;
      dec = (i == 1);
      wr(OFS_ENV, 32'h200 | (32'(i != 0) << ENV_ALARM_DECEL_BIT));
      wr(OFS_COMMAND, cmd);
      cyc(2);
      alarmOn <= 1'b1;
      cyc(8);
      chk({feedRun, decelStop}, {dec, dec});
      feedDone <= 1'b1;
      cyc(1);
      feedDone <= 1'b0;
      cyc(3);
      chk(feedRun, 1'b0);
      alarmOn <= 1'b0;
      cyc(8);
    end
    note("stop method");
    wr(OFS_ENV, 32'h200 | (32'h1 << ENV_FILTER_BIT));
    wr(OFS_COMMAND, CMD_START_CONST);
    alarmOn <= 1'b1;
    cyc(10 + int'(rnd() % 60));
    alarmOn <= 1'b0;
    cyc(90);
    chk(feedRun, 1'b1);
    alarmOn <= 1'b1;
    cyc(70);
    rd(OFS_SUBSTAT, RESP_OKAY, 32'h0, 32'h800);
    cyc(20);
    chk(feedRun, 1'b0);
    alarmOn <= 1'b0;
    cyc(90);
    note("alarm filter");
    wr(OFS_ENV, 32'h200);
    wr(OFS_OPMODE, 32'(WAIT_MODE_COMMON) << OPM_WAIT_LSB);
    wr(OFS_IRQEN, 32'h1 << IRQEN_START_BIT);
    wr(OFS_COMMAND, CMD_START_CONST);
    cyc(2);
    chk(feedRun, 1'b0);
    rd(OFS_EXTSTAT, RESP_OKAY, OPER_WAIT, 32'h2F);
    o = oeCnt;
    wr(OFS_COMMAND, CMD_SIMUL_START);
    cyc(20);
    chk(oeCnt - o, 8);
    chk({feedRun, irqReq}, 2'b11);
    rd(OFS_IRQCAUSE, RESP_OKAY, 32'h80000, 32'h80000);
    cyc(2);
    chk(irqReq, 1'b0);
    wr(OFS_COMMAND, CMD_IMM_STOP);
    hold <= 1'b1;
    cyc(6);
    rd(OFS_EXTSTAT, RESP_OKAY, 32'h20, 32'h20);
    wr(OFS_COMMAND, CMD_START_CONST);
    cyc(2);
    chk(feedRun, 1'b1);
    note("common start level");
    wr(OFS_COMMAND, CMD_IMM_STOP);
    wr(OFS_ENV, 32'h200 | (32'h1 << ENV_START_EDGE_BIT));
    wr(OFS_COMMAND, CMD_START_CONST);
    cyc(4);
    chk(feedRun, 1'b0);
    hold <= 1'b0;
    cyc(6);
    chk(feedRun, 1'b0);
    fire <= 1'b1;
    cyc(1);
    fire <= 1'b0;
    cyc(10);
    chk(feedRun, 1'b1);
    wr(OFS_COMMAND, CMD_IMM_STOP);
    note("common start edge");
    wr(OFS_COMMAND, CMD_START_CONST);
    o = oeCnt;
    wr(OFS_COMMAND, CMD_OWN_START);
    cyc(3);
    chk({feedRun, 32'(oeCnt - o)}, {1'b1, 32'h0});
    wr(OFS_COMMAND, CMD_IMM_STOP);
    wr(OFS_COMMAND, CMD_START_CONST);
    wr(OFS_COMMAND, CMD_IMM_STOP);
    rd(OFS_EXTSTAT, RESP_OKAY, OPER_IDLE, 32'hF);
    fire <= 1'b1;
    cyc(1);
    fire <= 1'b0;
    cyc(10);
    chk(feedRun, 1'b0);
    note("own start and cancel");
    cyc(3);
    test_done();
  end
endmodule
`default_nettype wire

/* verilog/axis_alarm_pkg.sv */
// Shared constants and types for the axis alarm and common start block.
package axis_alarm_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_COMMAND = 8'h00;
  localparam logic [7:0] OFS_ENV = 8'h04;
  localparam logic [7:0] OFS_OPMODE = 8'h08;
  localparam logic [7:0] OFS_IRQEN = 8'h0C;
  localparam logic [7:0] OFS_SUBSTAT = 8'h10;
  localparam logic [7:0] OFS_STOPCAUSE = 8'h14;
  localparam logic [7:0] OFS_EXTSTAT = 8'h18;
  localparam logic [7:0] OFS_IRQCAUSE = 8'h1C;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int ENV_ALARM_DECEL_BIT = 8;
  localparam int ENV_ALARM_POL_BIT = 9;
  localparam int ENV_START_EDGE_BIT = 18;
  localparam int ENV_FILTER_BIT = 26;
  localparam int OPM_WAIT_LSB = 18;
  localparam int IRQEN_START_BIT = 18;
  localparam int CAUSE_START_BIT = 19;
  localparam int SUB_ALARM_BIT = 11;
  localparam int STOP_ALARM_BIT = 7;
  localparam int EXT_LINE_BIT = 5;

  // ------------------------------------------------------------------
  // Field values and reset values
  // ------------------------------------------------------------------
  localparam logic [1:0] WAIT_MODE_COMMON = 2'h1;
  localparam logic [3:0] OPER_IDLE = 4'h0;
  localparam logic [3:0] OPER_RUN = 4'h1;
  localparam logic [3:0] OPER_WAIT = 4'h2;
  localparam logic [31:0] ENV_RESET = 32'h0000_0000;
  localparam logic [31:0] OPMODE_RESET = 32'h0000_0000;
  localparam logic [31:0] IRQEN_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // Commands
  // ------------------------------------------------------------------
  localparam logic [7:0] CMD_SIMUL_START = 8'h06;
  localparam logic [7:0] CMD_OWN_START = 8'h2A;
  localparam logic [7:0] CMD_IMM_STOP = 8'h49;
  localparam logic [7:0] CMD_START_CONST = 8'h50;
  localparam logic [7:0] CMD_START_FAST = 8'h51;

  // ------------------------------------------------------------------
  // Timing counts in reference clock cycles
  // ------------------------------------------------------------------
  localparam logic [6:0] ALARM_FILTER_CYCLES = 7'h50;
  localparam logic [6:0] RAW_MIN_CYCLES = 7'h02;
  localparam logic [3:0] ONESHOT_CYCLES = 4'h8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10,
    ST_DECEL = 2'b11
  } axis_state_t;

endpackage

/* verilog/axis_alarm_stop_and_sync_start.sv */
// Axis alarm stop and common start line handling with an AXI4-Lite slave.
//
// Notes on behaviour
// - Alarm in motion halts; decelerates only after a fast start.
// - Stop-method bit: 0 halts at once, 1 decelerates for fast starts.
// - A start command written while the alarm is active emits no pulses.
// - Alarm needs 80 cycles active with filter on, 2 cycles with it off.
// - Environment bit 9 selects alarm polarity: 0 low, 1 high active.
// - Sub-status bit 11 reads 1 while the alarm is active.
// - A halt caused by the alarm sets stop cause bit 7.
// - Environment bit 26 filters out alarm pulses under 80 cycles.
// - Start-wait field 01 starts the axis when the start line goes low.
// - Waiting axes start together; any device may drive the line.
// - The common start line is always active low.
// - Enable bit 18: line activity raises the interrupt, cause bit 19.
// - Extension status reads 0010 while waiting; bit 5 shows the line.
// - Command 06h drives an 8-cycle low pulse and senses it back.
// - Environment bit 18 selects level (0) or edge (1) triggering.
// - In level mode a low line starts the waiting axis at once.
// - Unless start-wait field is 01, start commands launch the axis without the shared line.
// - Immediate stop 49h cancels waiting for the common start.
// - Command 2Ah acts like a line assertion for this axis only.
`timescale 1ns/1ns
`default_nettype none
module axis_alarm_stop_and_sync_start
  import axis_alarm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic alarmIn,
  input wire logic startLineIn,
  output logic startLineOut,
  output logic startLineOe,
  input wire logic feedDone,
  output logic feedRun,
  output logic decelStop,
  output logic irqReq
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] env;
    logic [31:0] opMode;
    logic [31:0] irqEn;
    logic stopAlarm;
    logic causeStart;
    logic irq;
    axis_state_t state;
    logic fast;
    logic decel;
    logic [3:0] pulseCnt;
    logic drive;
    logic linePrev;
  } top_state_t;

  top_state_t s;
  top_state_t next_s;
  logic alarmActive;
  logic lineActive;
  logic wrFire;
  logic rdFire;
  logic cmdWrite;
  logic [7:0] cmdCode;
  logic startCmd;
  logic stopCmd;
  logic ownCmd;
  logic simulCmd;
  logic lineRise;
  logic lineTrig;
  logic waitMode;
  logic [3:0] operCode;

  // ------------------------------------------------------------------
  // Input conditioning
  // ------------------------------------------------------------------
  input_sync_filter alarmFilter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(alarmIn),
    .activeHigh(s.env[ENV_ALARM_POL_BIT]),
    .filterOn(s.env[ENV_FILTER_BIT]),
    .level(alarmActive)
  );

  // The start line polarity is fixed low and has no setting.
  input_sync_filter startFilter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(startLineIn),
    .activeHigh(1'b0),
    .filterOn(1'b0),
    .level(lineActive)
  );

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  assign wrFire = s.awready && s.wready;
  assign rdFire = s.arready;
  assign cmdWrite = wrFire && (s_axi_awaddr == OFS_COMMAND) && s_axi_wstrb[0];
  assign cmdCode = s_axi_wdata[7:0];
  assign startCmd = cmdWrite && ((cmdCode == CMD_START_CONST) ||
                                 (cmdCode == CMD_START_FAST));
  assign stopCmd = cmdWrite && (cmdCode == CMD_IMM_STOP);
  assign ownCmd = cmdWrite && (cmdCode == CMD_OWN_START);
  assign simulCmd = cmdWrite && (cmdCode == CMD_SIMUL_START);
  assign lineRise = lineActive && !s.linePrev;
  assign waitMode = s.opMode[OPM_WAIT_LSB+1:OPM_WAIT_LSB] == WAIT_MODE_COMMON;
  assign lineTrig = s.env[ENV_START_EDGE_BIT] ? lineRise :
                    lineActive;
  assign operCode = (s.state == ST_WAIT) ? OPER_WAIT :
                    (s.state == ST_IDLE) ? OPER_IDLE : OPER_RUN;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.linePrev = lineActive;

    // Write channel: take address and data together, answer after both.
    next_s.awready = s_axi_awvalid && s_axi_wvalid && !s.awready &&
                     !s.bvalid;
    next_s.wready = s_axi_awvalid && s_axi_wvalid && !s.awready &&
                    !s.bvalid;
    if (wrFire) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      unique case (s_axi_awaddr)
        OFS_COMMAND: ;
        OFS_ENV: begin
          next_s.env = mergeBytes(s.env, s_axi_wdata, s_axi_wstrb);
        end
        OFS_OPMODE: begin
          next_s.opMode = mergeBytes(s.opMode, s_axi_wdata, s_axi_wstrb);
        end
        OFS_IRQEN: begin
          next_s.irqEn = mergeBytes(s.irqEn, s_axi_wdata, s_axi_wstrb);
        end
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end else if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Read channel: one-cycle address ready, data on the next edge.
    next_s.arready = s_axi_arvalid && !s.arready && !s.rvalid;
    if (rdFire) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        OFS_COMMAND, OFS_ENV, OFS_OPMODE, OFS_IRQEN: ;
        OFS_SUBSTAT: next_s.rdata[SUB_ALARM_BIT] = alarmActive;
        OFS_STOPCAUSE: next_s.rdata[STOP_ALARM_BIT] = s.stopAlarm;
        OFS_EXTSTAT: begin
          next_s.rdata[3:0] = operCode;
          next_s.rdata[EXT_LINE_BIT] = lineActive;
        end
        OFS_IRQCAUSE: next_s.rdata[CAUSE_START_BIT] = s.causeStart;
        default: next_s.rresp = RESP_SLVERR;
      endcase
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    // Event cause: reading it clears it, a new event in that cycle wins.
    if (rdFire && s_axi_araddr == OFS_IRQCAUSE) begin
      next_s.causeStart = 1'b0;
    end
    if (lineRise && s.irqEn[IRQEN_START_BIT]) begin
      next_s.causeStart = 1'b1;
    end
    next_s.irq = next_s.causeStart;

    // One-shot drive of the shared line; the pin reads it back.
    if (simulCmd && s.pulseCnt == 4'h0) begin
      next_s.pulseCnt = ONESHOT_CYCLES;
    end else if (s.pulseCnt != 4'h0) begin
      next_s.pulseCnt = s.pulseCnt - 4'h1;
    end
    next_s.drive = next_s.pulseCnt != 4'h0;

    // Axis sequencing.
    unique case (s.state)
      ST_IDLE: begin
        if (startCmd) begin
          next_s.fast = cmdCode == CMD_START_FAST;
          next_s.stopAlarm = alarmActive;
          if (alarmActive) begin
            next_s.state = ST_IDLE;
          end else if (!waitMode) begin
            next_s.state = ST_RUN;
          end else if (!s.env[ENV_START_EDGE_BIT] && lineActive) begin
            next_s.state = ST_RUN;
          end else begin
            next_s.state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (stopCmd) begin
          next_s.state = ST_IDLE;
        end else if (lineTrig || ownCmd) begin
          if (alarmActive) begin
            next_s.state = ST_IDLE;
            next_s.stopAlarm = 1'b1;
          end else begin
            next_s.state = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (stopCmd) begin
          next_s.state = ST_IDLE;
        end else if (alarmActive) begin
          next_s.stopAlarm = 1'b1;
          if (s.env[ENV_ALARM_DECEL_BIT] && s.fast) begin
            next_s.state = ST_DECEL;
          end else begin
            next_s.state = ST_IDLE;
          end
        end else if (feedDone) begin
          next_s.state = ST_IDLE;
        end
      end
      ST_DECEL: begin
        // The driver holds the alarm until the ramp reports done.
        if (stopCmd || feedDone) begin
          next_s.state = ST_IDLE;
        end
      end
    endcase
    next_s.decel = next_s.state == ST_DECEL;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.env <= ENV_RESET;
      s.opMode <= OPMODE_RESET;
      s.irqEn <= IRQEN_RESET;
      s.state <= ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;
  assign startLineOut = 1'b0;
  assign startLineOe = s.drive;
  assign feedRun = s.state[1];
  assign decelStop = s.decel;
  assign irqReq = s.irq;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence oneShotLow;
    startLineOe [*8] ##1 !startLineOe;
  endsequence

  a_alarm_hard_halt: assert property (
    s.state == ST_RUN && alarmActive && !stopCmd &&
    !(s.env[ENV_ALARM_DECEL_BIT] && s.fast) |=> !feedRun)
    else $error("Alarm did not halt the axis immediately.");

  a_alarm_decel_sel: assert property (
    s.state == ST_RUN && alarmActive && !stopCmd &&
    s.env[ENV_ALARM_DECEL_BIT] && s.fast |=> decelStop && feedRun)
    else $error("Alarm with decelerating method did not ramp down.");

  a_alarm_no_start: assert property (
    s.state == ST_IDLE && startCmd && alarmActive |=> !feedRun [*2])
    else $error("Axis started while the alarm was active.");

  a_alarm_cause_set: assert property (
    s.state == ST_RUN && alarmActive && !stopCmd |=> s.stopAlarm)
    else $error("Alarm halt did not record its cause.");

  a_oneshot_width: assert property (
    simulCmd && s.pulseCnt == 4'h0 |=> oneShotLow)
    else $error("Common start one-shot is not eight cycles long.");

  a_level_start: assert property (
    s.state == ST_WAIT && !s.env[ENV_START_EDGE_BIT] && lineActive &&
    !stopCmd && !alarmActive |=> s.state == ST_RUN)
    else $error("Level trigger did not start the waiting axis.");

  a_edge_holds_wait: assert property (
    s.state == ST_WAIT && s.env[ENV_START_EDGE_BIT] && !lineRise &&
    !cmdWrite |=> s.state == ST_WAIT)
    else $error("Edge mode left the wait state without an edge.");

  a_stop_cancels_wait: assert property (
    s.state == ST_WAIT && stopCmd |=> s.state == ST_IDLE ##1 !feedRun)
    else $error("Immediate stop did not cancel the wait.");

  a_start_irq: assert property (
    lineRise && s.irqEn[IRQEN_START_BIT] |=> irqReq && s.causeStart)
    else $error("Start line event did not raise the interrupt.");

endmodule
`default_nettype wire

/* verilog/input_sync_filter.sv */
// Two-stage synchroniser with a minimum-width input filter.
`timescale 1ns/1ns
`default_nettype none
module input_sync_filter
  import axis_alarm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pinIn,
  input wire logic activeHigh,
  input wire logic filterOn,
  output logic level
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [1:0] warm;
    logic [6:0] cnt;
    logic level;
  } filt_state_t;

  filt_state_t s;
  filt_state_t next_s;
  logic active;
  logic [6:0] thr;

  // The output follows the input only after thr identical samples.
  always_comb begin
    next_s = s;
    next_s.sync1 = pinIn;
    next_s.sync2 = s.sync1;
    next_s.warm = {s.warm[0], 1'b1};
    active = (s.sync2 == activeHigh);
    thr = filterOn ? ALARM_FILTER_CYCLES : RAW_MIN_CYCLES;
    // Counting waits until both stages hold pin samples, so the reset
    // value of the synchroniser can never show up as a false edge.
    if (s.warm[1] && active != s.level) begin
      if (s.cnt == thr - 7'h01) begin
        next_s.level = active;
        next_s.cnt = 7'h00;
      end else begin
        next_s.cnt = s.cnt + 7'h01;
      end
    end else begin
      next_s.cnt = 7'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;

  a_level_after_width: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(s.level) |-> $past(s.cnt) == $past(thr) - 7'h01)
    else $error("Filtered level changed before the minimum width.");

endmodule
`default_nettype wire
